// >>> rtl/frc_restart_ctrl.sv
// Front-panel restart, abort, break and fail-LED controller with AXI4-Lite registers.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module frc_restart_ctrl
  import frc_pkg::*;
#(
  parameter int DEB_CYC = DEBOUNCE_CYC,
  parameter int ON_CYC = BLINK_CYC,
  parameter int GAPC = GAP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_sw,
  input wire logic abort_sw,
  input wire logic console_active,
  input wire logic break_in,
  input wire logic [31:0] local_addr,
  output logic local_bus_reset_r,
  output logic backplane_system_reset_r,
  output logic periph_reset_r,
  output logic [2:0] nmi_ipl_r,
  output logic bp_remove_r,
  output logic fail_led_r,
  output logic eprom_sel_r,
  output logic irq_r,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // Switch conditioning
  // ----------------------------------------------------------------
  logic [1:0] sw_raw;
  logic [1:0] sw_db;
  logic [1:0] sw_prev_r;
  assign sw_raw = {abort_sw, reset_sw};

  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_deb
    logic s1_r;
    logic s2_r;
    logic db_r;
    logic [TMR_W-1:0] cnt_r;
    always_ff @(posedge clk) begin
      if (rst) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        db_r <= 1'b0;
        cnt_r <= '0;
      end else begin
        s1_r <= sw_raw[gi]; // R19
        s2_r <= s1_r;
        if (s2_r == db_r) begin
          cnt_r <= '0;
        end else if (cnt_r == TMR_W'(DEB_CYC - 1)) begin
          db_r <= s2_r; // R19
          cnt_r <= '0;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
    assign sw_db[gi] = db_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sw_prev_r <= 2'b00;
    end else begin
      sw_prev_r <= sw_db;
    end
  end

  logic rst_press, rst_release, abt_press, abt_release;
  assign rst_press = sw_db[0] & ~sw_prev_r[0];
  assign rst_release = ~sw_db[0] & sw_prev_r[0];
  assign abt_press = sw_db[1] & ~sw_prev_r[1];
  assign abt_release = ~sw_db[1] & sw_prev_r[1];

  // ----------------------------------------------------------------
  // Register state and bus decode
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r, mask_r, user_pc_r, user_sp_r;
  logic [3:0] status_r, fail_code_r;
  frc_settings_t settings_r;
  logic [7:0] awaddr_q_r;
  logic [31:0] wdata_q_r;
  logic [3:0] wstrb_q_r;
  logic aw_got_r, w_got_r;
  logic wr_fire, wr_ok, rd_fire, rd_ok;
  logic [31:0] rd_data;
  frc_rs_state_t rs_state_r;
  frc_bl_state_t bl_state_r;
  logic restore_r, suppress_abt_r, pulse_end;
  logic [4:0] pulse_cnt_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_ok = (awaddr_q_r[7:2] <= REG_STATE[7:2]) && (awaddr_q_r[7:2] != REG_STATE[7:2])
    && (awaddr_q_r[7:2] != REG_STATUS[7:2]);
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr[7:2])
      REG_CTRL[7:2]: rd_data = ctrl_r;
      REG_STATUS[7:2]: rd_data = {28'h000_0000, status_r};
      REG_MASK[7:2]: rd_data = mask_r;
      REG_SETTINGS[7:2]: rd_data = settings_r;
      REG_FAIL[7:2]: rd_data = {23'h00_0000, bl_state_r != BL_IDLE, 4'h0, fail_code_r};
      REG_USER_PC[7:2]: rd_data = user_pc_r;
      REG_USER_SP[7:2]: rd_data = user_sp_r;
      REG_STATE[7:2]: rd_data = {26'h000_0000, restore_r, rs_state_r, sw_db, 1'b0};
      default: begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Write channel: address and data are taken in either order.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_q_r <= 8'h00;
      wdata_q_r <= 32'h0000_0000;
      wstrb_q_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_q_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_q_r <= s_axi_wdata;
        wstrb_q_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: one cycle from address to data.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Software registers; hardware restarts take priority over a same-cycle write.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      mask_r <= MASK_RST;
      settings_r <= SETTINGS_RESTORE;
      fail_code_r <= 4'h0;
      user_pc_r <= USER_PC_INIT;
      user_sp_r <= USER_SP_INIT;
    end else begin
      if (wr_fire) begin
        unique case (awaddr_q_r[7:2])
          REG_CTRL[7:2]: ctrl_r <= merge(ctrl_r, wdata_q_r, wstrb_q_r); // R1
          REG_MASK[7:2]: mask_r <= merge(mask_r, wdata_q_r, wstrb_q_r);
          REG_SETTINGS[7:2]: settings_r <= merge(settings_r, wdata_q_r, wstrb_q_r);
          REG_FAIL[7:2]: fail_code_r <= wstrb_q_r[0] ? wdata_q_r[3:0] : fail_code_r;
          REG_USER_PC[7:2]: user_pc_r <= merge(user_pc_r, wdata_q_r, wstrb_q_r);
          REG_USER_SP[7:2]: user_sp_r <= merge(user_sp_r, wdata_q_r, wstrb_q_r);
          default: ;
        endcase
      end
      if (rs_state_r == RS_HELD && rst_release && sw_db[1]) begin
        settings_r <= SETTINGS_RESTORE; // R9 R10
      end
      if (pulse_end) begin
        user_pc_r <= USER_PC_INIT; // R16
        user_sp_r <= USER_SP_INIT; // R16
      end
    end
  end

  // ----------------------------------------------------------------
  // Restart sequencer
  // ----------------------------------------------------------------
  assign pulse_end = (rs_state_r == RS_PULSE) && (pulse_cnt_r == 5'(PULSE_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      rs_state_r <= RS_IDLE;
      pulse_cnt_r <= 5'h00;
      restore_r <= 1'b0;
      local_bus_reset_r <= 1'b0;
      backplane_system_reset_r <= 1'b0;
      periph_reset_r <= 1'b0;
    end else begin
      unique case (rs_state_r)
        RS_IDLE: if (rst_press) begin
          rs_state_r <= RS_HELD;
        end
        RS_HELD: if (rst_release) begin
          rs_state_r <= RS_PULSE; // R1
          pulse_cnt_r <= 5'h00;
          restore_r <= sw_db[1]; // R9
          local_bus_reset_r <= 1'b1; // R5
          // A restore is an on-board reset, so it never reaches the backplane.
          backplane_system_reset_r <= ctrl_r[CTRL_SYSCTL_BIT] && !sw_db[1]; // R4
          periph_reset_r <= !ctrl_r[CTRL_WARM_BIT] || sw_db[1]; // R2 R3
        end
        RS_PULSE: if (pulse_end) begin
          rs_state_r <= RS_IDLE;
          local_bus_reset_r <= 1'b0;
          backplane_system_reset_r <= 1'b0;
          periph_reset_r <= 1'b0;
        end else begin
          pulse_cnt_r <= pulse_cnt_r + 5'h01;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Abort interrupt and break
  // ----------------------------------------------------------------
  logic [3:0] nmi_cnt_r;
  logic nmi_ev, brk_prev_r, brk_ev;
  assign nmi_ev = abt_release && !suppress_abt_r;
  assign brk_ev = break_in && !brk_prev_r && console_active; // R15

  always_ff @(posedge clk) begin
    if (rst) begin
      suppress_abt_r <= 1'b0;
      nmi_ipl_r <= 3'h0;
      nmi_cnt_r <= 4'h0;
      brk_prev_r <= 1'b0;
      bp_remove_r <= 1'b0;
    end else begin
      brk_prev_r <= break_in;
      bp_remove_r <= brk_ev; // R15
      // The abort release that ends a restore chord must not also interrupt.
      if (rs_state_r == RS_HELD && rst_release && sw_db[1]) begin
        suppress_abt_r <= 1'b1; // R9
      end else if (abt_release) begin
        suppress_abt_r <= 1'b0;
      end
      if (nmi_ev) begin
        nmi_ipl_r <= NMI_LEVEL; // R8
        nmi_cnt_r <= 4'(NMI_HOLD_CYC - 1);
      end else if (nmi_cnt_r != 4'h0) begin
        nmi_cnt_r <= nmi_cnt_r - 4'h1;
      end else begin
        nmi_ipl_r <= 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [3:0] ev_vec;
  logic st_rd;
  assign ev_vec = {rs_state_r == RS_HELD && rst_release && sw_db[1], brk_ev, nmi_ev, pulse_end};
  assign st_rd = rd_fire && (s_axi_araddr[7:2] == REG_STATUS[7:2]);

  always_ff @(posedge clk) begin
    if (rst) begin
      status_r <= 4'h0;
      irq_r <= 1'b0;
    end else begin
      // A new event in the reading cycle survives the clear.
      status_r <= (st_rd ? 4'h0 : status_r) | ev_vec;
      irq_r <= |(status_r & mask_r[3:0] & IRQ_ALLOWED); // R15
    end
  end

  // ----------------------------------------------------------------
  // Fail LED blink codes
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] bl_tmr_r;
  logic [3:0] flash_n_r;
  logic wr_fail, tmr_on_done;
  assign wr_fail = wr_fire && awaddr_q_r[7:2] == REG_FAIL[7:2] && wstrb_q_r[0];
  assign tmr_on_done = bl_tmr_r == TMR_W'(ON_CYC - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      bl_state_r <= BL_IDLE;
      bl_tmr_r <= '0;
      flash_n_r <= 4'h0;
      fail_led_r <= 1'b0;
    end else if (abt_press || (wr_fail && wdata_q_r[3:0] == 4'h0)) begin
      bl_state_r <= BL_IDLE; // R14
      fail_led_r <= 1'b0;
    end else if (wr_fail) begin
      bl_state_r <= BL_ON; // R13
      bl_tmr_r <= '0;
      flash_n_r <= 4'h1;
      fail_led_r <= 1'b1;
    end else begin
      bl_tmr_r <= bl_tmr_r + 1'b1;
      unique case (bl_state_r)
        BL_IDLE: bl_tmr_r <= '0;
        BL_ON: if (tmr_on_done) begin
          bl_state_r <= BL_OFF; // R11
          bl_tmr_r <= '0;
          fail_led_r <= 1'b0;
        end
        BL_OFF: if (tmr_on_done) begin
          bl_tmr_r <= '0;
          if (flash_n_r == fail_code_r) begin
            bl_state_r <= BL_GAP; // R13
          end else begin
            bl_state_r <= BL_ON; // R11
            flash_n_r <= flash_n_r + 4'h1;
            fail_led_r <= 1'b1;
          end
        end
        BL_GAP: if (bl_tmr_r == TMR_W'(GAPC - 1)) begin
          bl_state_r <= BL_ON; // R12
          bl_tmr_r <= '0;
          flash_n_r <= 4'h1;
          fail_led_r <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      eprom_sel_r <= 1'b0;
    end else begin
      eprom_sel_r <= local_addr >= EPROM_BASE; // R17
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Helper for the restore check: open from a restore start until the abort switch is let go.
  logic chord_open_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      chord_open_r <= 1'b0;
    end else if (rs_state_r == RS_HELD && rst_release && sw_db[1]) begin
      chord_open_r <= 1'b1;
    end else if (abt_release) begin
      chord_open_r <= 1'b0;
    end
  end

  sequence restore_start_s;
    rs_state_r == RS_HELD && rst_release && sw_db[1];
  endsequence
  sequence plain_start_s;
    rs_state_r == RS_HELD && rst_release && !sw_db[1];
  endsequence

  restore_settings_a: assert property (restore_start_s |=> settings_r == SETTINGS_RESTORE && periph_reset_r) // R10
    else $error("restore did not load safe settings");
  nmi_hold_a: assert property (nmi_ev |=> (nmi_ipl_r == 3'h7) [*8] ##1 nmi_ipl_r == 3'h0) // R8
    else $error("abort interrupt level or length wrong");
  restore_no_nmi_a: assert property (chord_open_r && abt_release |-> !nmi_ev) // R9
    else $error("restore chord raised an interrupt");
  backplane_system_reset_cause_a: assert property ($rose(backplane_system_reset_r) |-> $past(ctrl_r[1]) && local_bus_reset_r) // R4
    else $error("backplane reset without system controller");
  warm_keep_a: assert property (plain_start_s and ctrl_r[0] |=> !periph_reset_r && local_bus_reset_r) // R3
    else $error("warm restart reset peripherals");
  pc_init_a: assert property (pulse_end |=> user_pc_r == 32'h0000_4000 && !local_bus_reset_r) // R16
    else $error("user PC not set after restart");
  break_gate_a: assert property ($rose(bp_remove_r) |-> $past(console_active)) // R15
    else $error("break seen without console traffic");
  blink_gap_a: assert property (bl_state_r == BL_OFF && tmr_on_done && flash_n_r == fail_code_r && !abt_press && !wr_fail
    |=> bl_state_r == BL_GAP && !fail_led_r) // R12
    else $error("blink code not followed by gap");
  status_clear_a: assert property (st_rd && ev_vec == 4'h0 |=> status_r == 4'h0) // R15
    else $error("status read did not clear");

endmodule : frc_restart_ctrl

// >>> rtl/frc_pkg.sv
// Constants, register map and types for the front-panel restart controller.
// What the document requires
// R1: Reset switch press-release starts a restart; cold or warm selectable, cold by default.
// R2: Cold restart resets on-board peripherals and clears monitor state like power-up.
// R3: Warm restart preserves monitor variables, saved user registers and breakpoints; the block still reloads user_pc_r and user_sp_r on every restart.
// R4: As system controller, a restart also asserts the backplane system reset.
// R5: Otherwise the restart is a local reset only, via the local bus reset.
// R6: Operator should stop backplane traffic with abort, keeping reset as last resort.
// R7: Operator must reset after a processor halt or a lost monitor environment.
// R8: Abort switch press-release raises a non-maskable level-seven interrupt.
// R9: Both pressed, reset released first: on-board reset plus settings restore.
// R10: Restore sets target id 7, console port 1, flags off, diagnostics once.
// R11: After a diagnostic failure the fail LED blinks a code, 0.25 s on and off.
// R12: Between code repetitions the fail LED stays off for about two seconds.
// R13: Blink count gives the failure, from 1 register up to 12 real-time clock.
// R14: Operator presses abort during blinking to let initialisation complete.
// R15: Break raises no interrupt, is seen only with console traffic, removes breakpoints.
// R16: Every restart sets user PC to 4000 hex and user stack inside user space.
// R17: Firmware EPROM sockets are decoded from address FF800000 upward.
// R18: Operator provides at least 16KB of contiguous monitor memory on board.
// R19: Reset and abort switches are synchronised and debounced before use.
package frc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_SETTINGS = 8'h0C;
  localparam logic [7:0] REG_FAIL = 8'h10;
  localparam logic [7:0] REG_USER_PC = 8'h14;
  localparam logic [7:0] REG_USER_SP = 8'h18;
  localparam logic [7:0] REG_STATE = 8'h1C;

  localparam int CTRL_WARM_BIT = 0;
  localparam int CTRL_SYSCTL_BIT = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;

  localparam int ST_RESTART_BIT = 0;
  localparam int ST_ABORT_BIT = 1;
  localparam int ST_BREAK_BIT = 2;
  localparam int ST_RESTORE_BIT = 3;
  localparam logic [3:0] IRQ_ALLOWED = 4'hB;

  localparam logic [31:0] SETTINGS_RESTORE = 32'h0000_040F;
  localparam logic [31:0] USER_PC_INIT = 32'h0000_4000;
  localparam logic [31:0] USER_SP_INIT = 32'h0000_8000;
  localparam logic [31:0] EPROM_BASE = 32'hFF80_0000;
  localparam logic [2:0] NMI_LEVEL = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_PERIOD_NS = 100;
  localparam longint BLINK_NS = 250_000_000;
  localparam longint GAP_NS = 2_000_000_000;
  localparam longint DEBOUNCE_NS = 10_000_000;
  localparam int BLINK_CYC = int'(BLINK_NS / CLK_PERIOD_NS);
  localparam int GAP_CYC = int'(GAP_NS / CLK_PERIOD_NS);
  localparam int DEBOUNCE_CYC = int'(DEBOUNCE_NS / CLK_PERIOD_NS);
  localparam int PULSE_CYC = 16;
  localparam int NMI_HOLD_CYC = 8;
  localparam int TMR_W = 25;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [20:0] rsvd;
    logic diag_once;
    logic mem_sized;
    logic concurrent;
    logic auto_bus_reset;
    logic rom_boot;
    logic auto_boot;
    logic [1:0] console_port;
    logic [2:0] target_id;
  } frc_settings_t;

  typedef enum logic [1:0] {RS_IDLE, RS_HELD, RS_PULSE} frc_rs_state_t;
  typedef enum logic [1:0] {BL_IDLE, BL_ON, BL_OFF, BL_GAP} frc_bl_state_t;

endpackage : frc_pkg

// >>> bench/frc_proc_model.sv
// Local processor and backplane model that counts what the restart controller drives.
`timescale 1ns/1ps
module frc_proc_model #(
  parameter int ON = 3
) (
  input wire logic clk,
  input wire logic clr,
  input wire logic lbr,
  input wire logic bpr,
  input wire logic prr,
  input wire logic bpm,
  input wire logic led,
  input wire logic [2:0] ipl
);
  int n_lbr, n_bpr, n_prr, n_nmi, n_bpm, low_run, on_len, burst, gap, f;
  // A low run longer than one off time marks the gap between two codes.
  always @(posedge clk) begin
    if (clr) begin
      n_lbr = 0; n_bpr = 0; n_prr = 0; n_nmi = 0; n_bpm = 0;
      low_run = 0; on_len = 0; burst = 0; gap = 0; f = 0;
    end else begin
      n_lbr += int'(lbr);
      n_bpr += int'(bpr);
      n_prr += int'(prr);
      n_nmi += int'(ipl === 3'h7);
      n_bpm += int'(bpm);
      if (led) begin
        if (low_run > ON) begin
          if (f > 0) gap = low_run;
          burst = f;
          f = 0;
        end
        if (low_run > 0) begin f++; on_len = 0; end
        on_len++;
        low_run = 0;
      end else begin
        low_run++;
      end
    end
  end
endmodule : frc_proc_model

// >>> bench/front_panel_restart_control_tb.sv
// Self-checking bench for the front-panel restart controller.
`timescale 1ns/1ps
module front_panel_restart_control_tb;
  import frc_pkg::*;
  localparam int DEB = 4;
  localparam int ON = 3;
  localparam int GP = 10;
  logic clk = 0, rst = 1, rsw = 0, asw = 0, cact = 0, brk = 0, clr = 0;
  logic [31:0] laddr = 0, wd = 0, rd;
  logic [7:0] awa = 0, ara = 0;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [3:0] ws = 0;
  logic lbr, bpr, prr, bpm, led, esel, irq, awr, wr, bv, arr, rv;
  logic [2:0] ipl;
  logic [1:0] br, rr, resp;
  int err_total = 0, n_tests = 0, seed = 32'h1b79, codes[4] = '{1, 7, 10, 12};
  logic [31:0] rnd;
  frc_settings_t exp_set;
  always #50 clk = ~clk;
  frc_restart_ctrl #(.DEB_CYC(DEB), .ON_CYC(ON), .GAPC(GP)) DUT (.clk(clk), .rst(rst), .reset_sw(rsw),
    .abort_sw(asw), .console_active(cact), .break_in(brk), .local_addr(laddr), .local_bus_reset_r(lbr),
    .backplane_system_reset_r(bpr), .periph_reset_r(prr), .nmi_ipl_r(ipl), .bp_remove_r(bpm),
    .fail_led_r(led), .eprom_sel_r(esel), .irq_r(irq), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
  frc_proc_model #(.ON(ON)) P (.clk(clk), .clr(clr), .lbr(lbr), .bpr(bpr), .prr(prr), .bpm(bpm),
    .led(led), .ipl(ipl));
  // ----------------------------------------------------------------
  // Bus and switch tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    awa <= a; wd <= d; ws <= 4'hF; awv <= 1; wv <= 1; bre <= 1;
    for (int n = 0; n < 50 && bv !== 1'b1; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
    end
    resp = br;
    bre <= 0; awv <= 0; wv <= 0;
    chk("bvalid", 1, bv);
    @(posedge clk);
  endtask : wr32
  task automatic rd32(input logic [7:0] a, output logic [31:0] q);
    ara <= a; arv <= 1; rre <= 1;
    for (int n = 0; n < 50 && rv !== 1'b1; n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
    end
    q = rd;
    resp = rr;
    rre <= 0; arv <= 0;
    chk("rvalid", 1, rv);
    @(posedge clk);
  endtask : rd32
  task automatic sw(input logic r, input logic a);
    rsw <= r; asw <= a;
    wait_cyc(DEB + 6);
  endtask : sw
  task automatic clear_counts;
    clr <= 1;
    wait_cyc(1);
    clr <= 0;
  endtask : clear_counts
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    exp_set = '0;
    exp_set.target_id = 3'h7;
    exp_set.console_port = 2'h1;
    exp_set.diag_once = 1'b1;
    wait_cyc(10);
    rst <= 0;
    wait_cyc(1);
    rd32(REG_CTRL, q); chk("ctrl", 32'h0000_0000, q);
    rd32(REG_SETTINGS, q); chk("settings", exp_set, q);
    rd32(8'h40, q); chk("unmapped", RESP_SLVERR, resp);
    wr32(REG_STATE, 32'hFFFF_FFFF); chk("ro write", RESP_SLVERR, resp);
    $display("test reset values done");
    // Restarts are issued with the bus idle, as the operator would.
    for (int m = 0; m < 4; m++) begin
      rnd = $random(seed);
      wr32(REG_CTRL, m);
      wr32(REG_USER_PC, rnd);
      wr32(REG_USER_SP, {18'h0_0000, rnd[13:0]});
      clear_counts();
      sw(1, 0);
      sw(0, 0);
      wait_cyc(30);
      chk("local reset", 16, P.n_lbr);
      chk("backplane reset", m[1] ? 16 : 0, P.n_bpr);
      chk("periph reset", m[0] ? 0 : 16, P.n_prr);
      rd32(REG_USER_PC, q); chk("user pc", 32'h0000_4000, q);
      rd32(REG_USER_SP, q); chk("user sp", 1, q >= 32'h0000_4000);
      rd32(REG_STATUS, q); chk("status", 1, q);
    end
    $display("test restart modes done");
    wr32(REG_MASK, 32'h0000_000F);
    chk("mask write", RESP_OKAY, resp);
    clear_counts();
    sw(0, 1);
    sw(0, 0);
    wait_cyc(10);
    chk("nmi cycles", 8, P.n_nmi);
    chk("irq set", 1, irq);
    rd32(REG_STATUS, q); chk("status", 2, q);
    wait_cyc(2); chk("irq clear", 0, irq);
    brk <= 1; wait_cyc(2); brk <= 0; wait_cyc(3);
    chk("break idle", 0, P.n_bpm);
    cact <= 1;
    brk <= 1; wait_cyc(2); brk <= 0; wait_cyc(3);
    chk("break pulse", 1, P.n_bpm);
    chk("break irq", 0, irq);
    chk("break nmi", 8, P.n_nmi);
    rd32(REG_STATUS, q); chk("status", 4, q);
    $display("test abort and break done");
    wr32(REG_CTRL, 32'h0000_0003);
    wr32(REG_SETTINGS, $random(seed) & 32'h0000_03F0);
    clear_counts();
    sw(1, 0);
    sw(1, 1);
    sw(0, 1);
    sw(0, 0);
    wait_cyc(20);
    rd32(REG_SETTINGS, q); chk("restored", exp_set, q);
    chk("restore nmi", 0, P.n_nmi);
    chk("restore backplane", 0, P.n_bpr);
    chk("restore local", 16, P.n_lbr);
    chk("restore periph", 16, P.n_prr);
    rd32(REG_STATUS, q); chk("restore flag", 1, q[3]);
    $display("test restore done");
    foreach (codes[i]) begin
      clear_counts();
      wr32(REG_FAIL, codes[i]);
      wait_cyc(2 * (2 * codes[i] * ON + GP) + 10);
      chk("flashes", codes[i], P.burst);
      chk("on time", ON, P.on_len);
      chk("gap", ON + GP, P.gap);
      wr32(REG_FAIL, 0);
    end
    wr32(REG_FAIL, 3);
    wait_cyc(10);
    sw(0, 1);
    rd32(REG_FAIL, q); chk("blink stop", 0, q[8]);
    chk("led off", 0, led);
    sw(0, 0);
    $display("test blink codes done");
    laddr <= EPROM_BASE; wait_cyc(2); chk("eprom hit", 1, esel);
    laddr <= 32'hFF7F_FFFF; wait_cyc(2); chk("eprom miss", 0, esel);
    $display("test eprom decode done");
    tally_and_finish();
  end
  initial begin
    #(100 * 20000);
    err_total++;
    $display("BAD watchdog expected finish seen hang");
    tally_and_finish();
  end
endmodule : front_panel_restart_control_tb
